// file: logic/fmv_seq.sv
// Command sequencer with APB registers for margin setting and D-Flash section verify.
// Assumes the flash read port answers each held request with an ack pulse.
//
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/100ps
module fmv_seq (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic special_mode,
   output fmv_pkg::fmv_rd_req_type rd_req,
   input wire fmv_pkg::fmv_rd_rsp_type rd_rsp,
   output fmv_pkg::fmv_levels_type margin_levels,
   output logic cmd_irq
);
   fmv_pkg::fmv_seq_state_type q;
   fmv_pkg::fmv_seq_state_type d;
   fmv_pkg::fmv_op_type chk_op;
   logic chk_err;
   logic wr_acc;
   logic mapped;
   logic launch;
   logic margin_wr;
   logic read_bad;

   // ====================================================================
   // Parameter checking and margin storage
   fmv_cmd_check u_check (
      .words(q.words),
      .idx(q.idx),
      .special_mode(special_mode),
      .op(chk_op),
      .err(chk_err)
   );

   fmv_margin_store u_store (
      .pclk(pclk),
      .presetn(presetn),
      .wr_en(margin_wr),
      .wr_blk(q.words[0][6:0]),
      .wr_level(q.words[1][2:0]),
      .levels(margin_levels)
   );

   // ====================================================================
   // APB decode
   assign mapped = (paddr == fmv_pkg::FMV_CFG_OFS) || (paddr == fmv_pkg::FMV_STAT_OFS)
      || (paddr == fmv_pkg::FMV_IDX_OFS) || (paddr == fmv_pkg::FMV_WORD_OFS);
   assign wr_acc = psel && penable && pwrite && mapped;
   // Launch is ignored while an earlier error is still pending, as software must clear it first
   assign launch = wr_acc && (paddr == fmv_pkg::FMV_STAT_OFS)
      && pwdata[fmv_pkg::FMV_STAT_DONE_BIT] && q.fl.done && !q.fl.access_error_flag && !q.fl.pviol;
   assign read_bad = rd_rsp.err || (rd_rsp.data != fmv_pkg::FMV_ERASED_WORD);
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign prdata = q.rdata;

   // ====================================================================
   // Next state
   always_comb begin
      d = q;
      margin_wr = 1'b0;
      // Read data captured in the setup cycle so it comes from a flop
      if (psel && !penable) begin
         d.rdata = '0;
         if (paddr == fmv_pkg::FMV_CFG_OFS) begin
            d.rdata[fmv_pkg::FMV_CFG_IRQEN_BIT] = q.irq_en;
         end else if (paddr == fmv_pkg::FMV_STAT_OFS) begin
            d.rdata[fmv_pkg::FMV_STAT_DONE_BIT] = q.fl.done;
            d.rdata[fmv_pkg::FMV_STAT_ACCESS_ERROR_FLAG_BIT] = q.fl.access_error_flag;
            d.rdata[fmv_pkg::FMV_STAT_PVIOL_BIT] = q.fl.pviol;
            d.rdata[fmv_pkg::FMV_STAT_VERR_BIT] = q.fl.verr;
            d.rdata[fmv_pkg::FMV_STAT_VUNC_BIT] = q.fl.vunc;
         end else if (paddr == fmv_pkg::FMV_IDX_OFS) begin
            d.rdata[2:0] = q.idx;
         end else if (paddr == fmv_pkg::FMV_WORD_OFS) begin
            d.rdata[15:0] = q.words[q.idx];
         end
      end
      if (wr_acc && (paddr == fmv_pkg::FMV_CFG_OFS)) begin
         d.irq_en = pwdata[fmv_pkg::FMV_CFG_IRQEN_BIT];
      end
      // Parameters are frozen while a command runs so checks stay valid
      if (wr_acc && (paddr == fmv_pkg::FMV_IDX_OFS) && q.fl.done) begin
         d.idx = pwdata[2:0];
      end
      if (wr_acc && (paddr == fmv_pkg::FMV_WORD_OFS) && q.fl.done) begin
         d.words[q.idx] = pwdata[15:0];
      end
      if (wr_acc && (paddr == fmv_pkg::FMV_STAT_OFS)) begin
         if (pwdata[fmv_pkg::FMV_STAT_ACCESS_ERROR_FLAG_BIT]) begin
            d.fl.access_error_flag = 1'b0;
         end
         if (pwdata[fmv_pkg::FMV_STAT_PVIOL_BIT]) begin
            d.fl.pviol = 1'b0;
         end
      end
      // Hardware sets below come after the clears, so a set wins
      case (q.st)
         fmv_pkg::FMV_ST_IDLE: begin
            if (launch) begin
               d.fl.verr = 1'b0;
               d.fl.vunc = 1'b0;
               if (chk_err) begin
                  // Rejected command never runs and completion stays set
                  d.fl.access_error_flag = 1'b1;
               end else if (chk_op == fmv_pkg::FMV_OP_MARGIN) begin
                  d.fl.done = 1'b0;
                  d.st = fmv_pkg::FMV_ST_MARGIN;
               end else begin
                  d.fl.done = 1'b0;
                  d.addr = {q.words[0][6:0], q.words[1]};
                  d.left = q.words[2];
                  if (q.words[2] == fmv_pkg::FMV_WORD_RESET) begin
                     d.st = fmv_pkg::FMV_ST_DONE;
                  end else begin
                     d.rd_req = 1'b1;
                     d.st = fmv_pkg::FMV_ST_VERIFY;
                  end
               end
            end
         end
         fmv_pkg::FMV_ST_MARGIN: begin
            // Protection flag is not touched by margin commands
            margin_wr = 1'b1;
            d.st = fmv_pkg::FMV_ST_DONE;
         end
         fmv_pkg::FMV_ST_VERIFY: begin
            if (rd_rsp.ack) begin
               if (read_bad || rd_rsp.uncorr) begin
                  d.fl.verr = 1'b1;
               end
               if (rd_rsp.uncorr) begin
                  d.fl.vunc = 1'b1;
               end
               d.addr = q.addr + fmv_pkg::FMV_WORD_STEP;
               d.left = q.left - 16'h0001;
               if (q.left == 16'h0001) begin
                  d.rd_req = 1'b0;
                  d.st = fmv_pkg::FMV_ST_DONE;
               end
            end
         end
         fmv_pkg::FMV_ST_DONE: begin
            d.fl.done = 1'b1;
            d.st = fmv_pkg::FMV_ST_IDLE;
         end
         default: begin
            d.st = fmv_pkg::FMV_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q.st <= fmv_pkg::FMV_ST_IDLE;
         q.irq_en <= 1'b0;
         q.fl <= 5'b10000;
         q.idx <= fmv_pkg::FMV_IDX_RESET;
         q.words <= '0;
         q.addr <= '0;
         q.left <= fmv_pkg::FMV_WORD_RESET;
         q.rd_req <= 1'b0;
         q.rdata <= '0;
      end else begin
         q <= d;
      end
   end

   // ====================================================================
   // Outputs
   assign rd_req.req = q.rd_req;
   assign rd_req.addr = q.addr;
   assign cmd_irq = q.fl.done && q.irq_en;

   // ====================================================================
   // Assertions
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_launch_runs: assert property (
      launch && !chk_err |=> !q.fl.done && !q.fl.access_error_flag)
      else $error("accepted launch did not clear completion");

   a_reject_flags: assert property (
      launch && chk_err |=> q.fl.done && q.fl.access_error_flag
      && q.st == fmv_pkg::FMV_ST_IDLE)
      else $error("rejected launch did not flag access error");

   a_margin_seq: assert property (
      q.st == fmv_pkg::FMV_ST_MARGIN |-> margin_wr
      ##1 (q.st == fmv_pkg::FMV_ST_DONE) ##1 q.fl.done)
      else $error("margin command did not record and complete");

   a_margin_apply: assert property (
      margin_wr && q.words[0][6:0] == fmv_pkg::FMV_DF_BLOCK_ID
      |=> margin_levels[1] == $past(q.words[1][2:0]))
      else $error("margin level not stored for its block");

   a_field_mode: assert property (
      launch && !special_mode
      && q.words[0][15:8] == fmv_pkg::FMV_CMD_FIELD_MARGIN |=> q.fl.access_error_flag)
      else $error("field margin accepted outside special mode");

   a_margin_index: assert property (
      launch && chk_op == fmv_pkg::FMV_OP_MARGIN
      && q.idx != fmv_pkg::FMV_IDX_MARGIN |=> q.fl.access_error_flag)
      else $error("margin command with wrong index accepted");

   a_margin_block: assert property (
      launch && chk_op == fmv_pkg::FMV_OP_MARGIN
      && !fmv_pkg::fmv_block_valid(q.words[0][6:0]) |=> q.fl.access_error_flag)
      else $error("margin command to a missing block accepted");

   a_user_level: assert property (
      launch
      && q.words[0][15:8] == fmv_pkg::FMV_CMD_USER_MARGIN
      && q.words[1] > fmv_pkg::FMV_LVL_USER_MAX |=> q.fl.access_error_flag)
      else $error("bad user margin level accepted");

   a_field_level: assert property (
      launch
      && q.words[0][15:8] == fmv_pkg::FMV_CMD_FIELD_MARGIN
      && q.words[1] > fmv_pkg::FMV_LVL_FIELD_MAX |=> q.fl.access_error_flag)
      else $error("bad field margin level accepted");

   a_level_range: assert property (
      margin_levels[0] <= fmv_pkg::FMV_LVL_FIELD_MAX
      && margin_levels[1] <= fmv_pkg::FMV_LVL_FIELD_MAX)
      else $error("stored margin level out of range");

   // ====================================================================
   // Section verify and read port
   a_verify_index: assert property (
      launch && chk_op == fmv_pkg::FMV_OP_VERIFY
      && q.idx != fmv_pkg::FMV_IDX_COUNT |=> q.fl.access_error_flag)
      else $error("verify with wrong index accepted");

   a_verify_space: assert property (
      launch && chk_op == fmv_pkg::FMV_OP_VERIFY
      && (q.words[0][6:0] != fmv_pkg::FMV_DF_BLOCK_ID
      || {2'b00, q.words[1]} >= fmv_pkg::FMV_DF_SIZE) |=> q.fl.access_error_flag)
      else $error("verify outside D-Flash accepted");

   a_verify_align: assert property (
      launch && chk_op == fmv_pkg::FMV_OP_VERIFY
      && q.words[1][0] |=> q.fl.access_error_flag)
      else $error("misaligned verify accepted");

   a_verify_end: assert property (
      launch && chk_op == fmv_pkg::FMV_OP_VERIFY
      && {2'b00, q.words[1]} + {1'b0, q.words[2], 1'b0} > fmv_pkg::FMV_DF_SIZE
      |=> q.fl.access_error_flag)
      else $error("verify past block end accepted");

   a_pviol_kept: assert property (
      q.st != fmv_pkg::FMV_ST_IDLE |=> $stable(q.fl.pviol))
      else $error("protection flag changed by a command");

   a_read_hold: assert property (
      rd_req.req && !rd_rsp.ack |=> rd_req.req
      && $stable(rd_req.addr))
      else $error("read request dropped before ack");

   a_read_idle: assert property (
      q.st != fmv_pkg::FMV_ST_VERIFY |-> !rd_req.req)
      else $error("read request outside a verify");

   a_verify_last: assert property (
      q.st == fmv_pkg::FMV_ST_VERIFY && rd_rsp.ack && q.left == 16'h0001
      |=> !rd_req.req ##1 q.fl.done)
      else $error("verify did not complete after its last word");

   a_verify_empty: assert property (
      launch && !chk_err && chk_op == fmv_pkg::FMV_OP_VERIFY
      && q.words[2] == fmv_pkg::FMV_WORD_RESET |=> q.st == fmv_pkg::FMV_ST_DONE)
      else $error("empty verify did not complete at once");

   a_read_error: assert property (
      q.st == fmv_pkg::FMV_ST_VERIFY && rd_rsp.ack
      && read_bad |=> q.fl.verr)
      else $error("verify error not flagged");

   a_read_uncorr: assert property (
      q.st == fmv_pkg::FMV_ST_VERIFY && rd_rsp.ack
      && rd_rsp.uncorr |=> q.fl.vunc && q.fl.verr)
      else $error("uncorrectable error not flagged");

   // ====================================================================
   // Completion interrupt
   a_irq_level: assert property (
      $rose(q.fl.done) && q.irq_en |-> cmd_irq)
      else $error("completion interrupt missing");

   c_margin_done: cover property (q.st == fmv_pkg::FMV_ST_MARGIN ##2 q.fl.done);
   c_verify_done: cover property (q.st == fmv_pkg::FMV_ST_VERIFY
      ##1 q.st == fmv_pkg::FMV_ST_DONE);
   c_verify_fail: cover property (q.fl.verr && q.fl.done);
   c_rejected: cover property (launch && chk_err);
   c_irq_raised: cover property ($rose(cmd_irq));
endmodule

// file: include/fmv_pkg.sv
// Constants, types and shared decode for the margin and D-Flash verify sequencer.
// Assumes an APB master with a 40 MHz pclk and an external flash read port.
// ====================================================================
// Notes on behaviour
// - A chosen margin level applies to later reads of one selected block.
// - Valid user margin command records level for block, then sets completion flag.
// - User margin accepts only settings 0x0000, 0x0001 and 0x0002.
// - Margin commands flag access error unless parameter index is 001 at launch.
// - Any command not allowed in the current mode flags access error.
// - Margin commands flag access error when block bits select no flash block.
// - Margin commands flag access error for a setting outside their valid set.
// - Field margin, code 0x0E, only in special mode; same layout as user margin.
// - Valid field margin command records level for block, then sets completion flag.
// - Field margin accepts settings 0x0000 up to 0x0004.
// - Section verify reads count words from start, checks erased, then completes.
// - Section verify flags access error unless parameter index is 010 at launch.
// - Section verify flags access error when address lies outside D-Flash space.
// - Section verify flags access error when start address bit 0 is set.
// - Section verify flags access error when the section runs past block end.
// - Verify sets first status flag on read error, second when uncorrectable.
// - Command interrupt requested while completion flag and its enable are both set.
package fmv_pkg;
   // ====================================================================
   // Register map, byte addresses
   localparam logic [7:0] FMV_CFG_OFS = 8'h00;
   localparam logic [7:0] FMV_STAT_OFS = 8'h04;
   localparam logic [7:0] FMV_IDX_OFS = 8'h08;
   localparam logic [7:0] FMV_WORD_OFS = 8'h0c;
   localparam int FMV_CFG_IRQEN_BIT = 7;
   localparam int FMV_STAT_DONE_BIT = 7;
   localparam int FMV_STAT_ACCESS_ERROR_FLAG_BIT = 5;
   localparam int FMV_STAT_PVIOL_BIT = 4;
   localparam int FMV_STAT_VERR_BIT = 1;
   localparam int FMV_STAT_VUNC_BIT = 0;
   // ====================================================================
   // Commands and parameter slots
   localparam logic [7:0] FMV_CMD_USER_MARGIN = 8'h0d;
   localparam logic [7:0] FMV_CMD_FIELD_MARGIN = 8'h0e;
   localparam logic [7:0] FMV_CMD_VERIFY_DF = 8'h10;
   localparam logic [2:0] FMV_IDX_BLOCK = 3'h0;
   localparam logic [2:0] FMV_IDX_MARGIN = 3'h1;
   localparam logic [2:0] FMV_IDX_COUNT = 3'h2;
   localparam int FMV_NUM_WORDS = 8;
   localparam logic [15:0] FMV_LVL_NORMAL = 16'h0000;
   localparam logic [15:0] FMV_LVL_USER_MAX = 16'h0002;
   localparam logic [15:0] FMV_LVL_FIELD_MAX = 16'h0004;
   // ====================================================================
   // Flash geometry; block numbers are global address bits 22:16
   localparam logic [6:0] FMV_PF_BLOCK_ID = 7'h7f;
   localparam logic [6:0] FMV_DF_BLOCK_ID = 7'h10;
   localparam logic [17:0] FMV_DF_SIZE = 18'h08000;
   localparam logic [15:0] FMV_ERASED_WORD = 16'hffff;
   localparam logic [22:0] FMV_WORD_STEP = 23'h000002;
   localparam int FMV_NUM_BLOCKS = 2;
   // ====================================================================
   // Reset values
   localparam logic [2:0] FMV_IDX_RESET = 3'h0;
   localparam logic [15:0] FMV_WORD_RESET = 16'h0000;

   typedef enum logic [1:0] {
      FMV_ST_IDLE = 2'b00,
      FMV_ST_MARGIN = 2'b01,
      FMV_ST_VERIFY = 2'b11,
      FMV_ST_DONE = 2'b10
   } fmv_state_type;

   typedef enum logic [1:0] {
      FMV_OP_NONE = 2'b00,
      FMV_OP_MARGIN = 2'b01,
      FMV_OP_VERIFY = 2'b10
   } fmv_op_type;

   typedef struct packed {
      logic done;
      logic access_error_flag;
      logic pviol;
      logic verr;
      logic vunc;
   } fmv_flags_type;

   typedef struct packed {
      logic req;
      logic [22:0] addr;
   } fmv_rd_req_type;

   typedef struct packed {
      logic ack;
      logic [15:0] data;
      logic err;
      logic uncorr;
   } fmv_rd_rsp_type;

   typedef logic [FMV_NUM_WORDS-1:0][15:0] fmv_words_type;
   typedef logic [FMV_NUM_BLOCKS-1:0][2:0] fmv_levels_type;

   typedef struct packed {
      fmv_state_type st;
      logic irq_en;
      fmv_flags_type fl;
      logic [2:0] idx;
      fmv_words_type words;
      logic [22:0] addr;
      logic [15:0] left;
      logic rd_req;
      logic [31:0] rdata;
   } fmv_seq_state_type;

   // Flash block present at these upper address bits
   function automatic logic fmv_block_valid(input logic [6:0] blk);
      return (blk == FMV_PF_BLOCK_ID) || (blk == FMV_DF_BLOCK_ID);
   endfunction

   // Slot of a block in the margin store
   function automatic logic fmv_block_slot(input logic [6:0] blk);
      return blk == FMV_DF_BLOCK_ID;
   endfunction
endpackage

// file: logic/fmv_cmd_check.sv
// Launch-time parameter checking for the three commands.
// Assumes parameter words stay frozen while a command runs.
`timescale 1ns/100ps
module fmv_cmd_check (
   input wire fmv_pkg::fmv_words_type words,
   input wire logic [2:0] idx,
   input wire logic special_mode,
   output fmv_pkg::fmv_op_type op,
   output logic err
);
   logic [7:0] cmd;
   logic [6:0] blk;
   logic [15:0] lvl;
   logic [17:0] end_addr;

   assign cmd = words[0][15:8];
   assign blk = words[0][6:0];
   assign lvl = words[1];
   // Sized so a full 16-bit count cannot wrap
   assign end_addr = {2'b00, words[1]} + {1'b0, words[2], 1'b0};

   always_comb begin
      op = fmv_pkg::FMV_OP_NONE;
      err = 1'b1;
      case (cmd)
         fmv_pkg::FMV_CMD_USER_MARGIN: begin
            op = fmv_pkg::FMV_OP_MARGIN;
            err = (idx != fmv_pkg::FMV_IDX_MARGIN)
               || !fmv_pkg::fmv_block_valid(blk)
               || (lvl > fmv_pkg::FMV_LVL_USER_MAX);
         end
         fmv_pkg::FMV_CMD_FIELD_MARGIN: begin
            op = fmv_pkg::FMV_OP_MARGIN;
            err = (idx != fmv_pkg::FMV_IDX_MARGIN)
               || !special_mode
               || !fmv_pkg::fmv_block_valid(blk)
               || (lvl > fmv_pkg::FMV_LVL_FIELD_MAX);
         end
         fmv_pkg::FMV_CMD_VERIFY_DF: begin
            op = fmv_pkg::FMV_OP_VERIFY;
            err = (idx != fmv_pkg::FMV_IDX_COUNT)
               || (blk != fmv_pkg::FMV_DF_BLOCK_ID)
               || ({2'b00, words[1]} >= fmv_pkg::FMV_DF_SIZE)
               || words[1][0]
               || (end_addr > fmv_pkg::FMV_DF_SIZE);
         end
         default: begin
            op = fmv_pkg::FMV_OP_NONE;
            err = 1'b1;
         end
      endcase
   end
endmodule

// file: logic/fmv_margin_store.sv
// Per-block read margin levels, driven to the flash array read path.
// Assumes a one-cycle write strobe from the sequencer.
`timescale 1ns/100ps
module fmv_margin_store (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic wr_en,
   input wire logic [6:0] wr_blk,
   input wire logic [2:0] wr_level,
   output fmv_pkg::fmv_levels_type levels
);
   fmv_pkg::fmv_levels_type lv_q;
   fmv_pkg::fmv_levels_type lv_d;

   // Each block holds its level until rewritten or reset
   always_comb begin
      lv_d = lv_q;
      if (wr_en) begin
         lv_d[fmv_pkg::fmv_block_slot(wr_blk)] = wr_level;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lv_q <= '0;
      end else begin
         lv_q <= lv_d;
      end
   end

   assign levels = lv_q;

   a_level_hold: assert property (@(posedge pclk) disable iff (!presetn)
      !wr_en |=> $stable(lv_q)) else $error("margin level changed without a write");
endmodule

// file: tb/tb.sv
// Self-checking bench for the margin and D-Flash verify sequencer.
// Assumes fmv_pkg is compiled first; the bench is APB master and flash read port.
`timescale 1ns/100ps
module tb;
   typedef struct packed {
      logic [7:0] cmd;
      logic [6:0] blk;
      logic [15:0] w1;
      logic [15:0] w2;
      logic [2:0] idx;
      logic spec;
      logic [1:0] inj;
      logic bad;
   } fmv_tb_row_type;
   // ====================================================================
   // Command table: code, block, word1, word2, index, special, injection, rejected
   localparam int NR = 21;
   localparam fmv_tb_row_type ROWS [NR] = '{
      '{8'h0d, 7'h7f, 16'h0001, 16'h0000, 3'h1, 1'b0, 2'h0, 1'b0},
      '{8'h0d, 7'h10, 16'h0002, 16'h0000, 3'h1, 1'b0, 2'h0, 1'b0},
      '{8'h0d, 7'h10, 16'h0003, 16'h0000, 3'h1, 1'b0, 2'h0, 1'b1},
      '{8'h0e, 7'h10, 16'h0004, 16'h0000, 3'h1, 1'b0, 2'h0, 1'b1},
      '{8'h0e, 7'h10, 16'h0004, 16'h0000, 3'h1, 1'b1, 2'h0, 1'b0},
      '{8'h0e, 7'h7f, 16'h0003, 16'h0000, 3'h1, 1'b1, 2'h0, 1'b0},
      '{8'h0e, 7'h7f, 16'h0005, 16'h0000, 3'h1, 1'b1, 2'h0, 1'b1},
      '{8'h0d, 7'h7f, 16'h0000, 16'h0000, 3'h1, 1'b1, 2'h0, 1'b0},
      '{8'h0d, 7'h20, 16'h0001, 16'h0000, 3'h1, 1'b0, 2'h0, 1'b1},
      '{8'h0d, 7'h7f, 16'h0002, 16'h0000, 3'h2, 1'b0, 2'h0, 1'b1},
      '{8'h10, 7'h10, 16'h0000, 16'h0004, 3'h2, 1'b0, 2'h0, 1'b0},
      '{8'h10, 7'h10, 16'h0010, 16'h0003, 3'h2, 1'b0, 2'h1, 1'b0},
      '{8'h10, 7'h10, 16'h0020, 16'h0002, 3'h2, 1'b0, 2'h2, 1'b0},
      '{8'h10, 7'h10, 16'h0030, 16'h0002, 3'h2, 1'b0, 2'h3, 1'b0},
      '{8'h10, 7'h10, 16'h0001, 16'h0001, 3'h2, 1'b0, 2'h0, 1'b1},
      '{8'h10, 7'h10, 16'h7ffe, 16'h0001, 3'h2, 1'b0, 2'h0, 1'b0},
      '{8'h10, 7'h10, 16'h7ffe, 16'h0002, 3'h2, 1'b0, 2'h0, 1'b1},
      '{8'h10, 7'h7f, 16'h0000, 16'h0001, 3'h2, 1'b0, 2'h0, 1'b1},
      '{8'h10, 7'h10, 16'h8000, 16'h0001, 3'h2, 1'b0, 2'h0, 1'b1},
      '{8'h10, 7'h10, 16'h0000, 16'h0001, 3'h1, 1'b0, 2'h0, 1'b1},
      '{8'h10, 7'h10, 16'h0000, 16'h0000, 3'h2, 1'b0, 2'h0, 1'b0}
   };
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic special_mode = 1'b0;
   fmv_pkg::fmv_rd_req_type rd_req;
   fmv_pkg::fmv_rd_rsp_type rd_rsp = '0;
   fmv_pkg::fmv_levels_type margin_levels;
   logic cmd_irq;
   logic [1:0] inj = 2'h0;
   logic [22:0] base_addr = 23'h000000;
   logic [2:0] exp_lvl [2] = '{3'h0, 3'h0};
   int ack_total = 0;
   int ack_base = 0;
   int cyc = 0;
   int err_total = 0;
   int n_tests = 0;

   fmv_seq u_fmv_seq (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .special_mode(special_mode), .rd_req(rd_req), .rd_rsp(rd_rsp),
      .margin_levels(margin_levels), .cmd_irq(cmd_irq));

   always #12.5 pclk = ~pclk;

   // ====================================================================
   // Checks and closing
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         $display("BAD %s expected %h seen %h", nm, e, g);
         err_total++;
      end
   endtask

   task automatic print_verdict;
      $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Cycle ceiling well above the longest expected run
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_total++;
         print_verdict();
      end
   end

   // ====================================================================
   // Flash read port: every other cycle ack, errors injected at the start word
   always @(posedge pclk) begin
      if (rd_req.req && rd_rsp.ack) begin
         chk("read addr", 32'(base_addr + 23'(2 * (ack_total - ack_base))), 32'(rd_req.addr));
         ack_total <= ack_total + 1;
      end
      if (rd_req.req && !rd_rsp.ack) begin
         rd_rsp.ack <= 1'b1;
         rd_rsp.data <= (inj == 2'h1 && rd_req.addr == base_addr) ? 16'h1234 : 16'hffff;
         rd_rsp.err <= inj == 2'h3 && rd_req.addr == base_addr;
         rd_rsp.uncorr <= inj == 2'h2 && rd_req.addr == base_addr;
      end else begin
         // Idle data toggles so a stale word is never mistaken for a fresh one
         rd_rsp.ack <= 1'b0;
         rd_rsp.data <= ~rd_rsp.data;
         rd_rsp.err <= 1'b0;
         rd_rsp.uncorr <= 1'b0;
      end
   end

   // ====================================================================
   // APB master; entered just after a rising edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] rd, output logic er);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      logic e;
      apb(1'b1, a, d, x, e);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      logic e;
      apb(1'b0, a, 32'h00000000, d, e);
      chk("slverr", 32'h0, 32'(e));
   endtask

   task automatic put(input logic [2:0] i, input logic [15:0] w);
      wr(fmv_pkg::FMV_IDX_OFS, 32'(i));
      wr(fmv_pkg::FMV_WORD_OFS, 32'(w));
   endtask

   task automatic launch_wait(output logic [31:0] d);
      int i;
      ack_base = ack_total;
      wr(fmv_pkg::FMV_STAT_OFS, 32'h00000080);
      for (i = 0; i < 100; i++) begin
         rd(fmv_pkg::FMV_STAT_OFS, d);
         if (d[7] === 1'b1) break;
      end
      chk("complete", 32'h1, 32'(d[7]));
   endtask

   task automatic run_row(input fmv_tb_row_type r);
      logic [31:0] d;
      logic vf;
      vf = r.cmd == fmv_pkg::FMV_CMD_VERIFY_DF;
      special_mode <= r.spec;
      inj <= r.inj;
      base_addr <= {r.blk, r.w1};
      put(3'h0, {r.cmd, 1'b0, r.blk});
      put(3'h1, r.w1);
      put(3'h2, r.w2);
      wr(fmv_pkg::FMV_IDX_OFS, 32'(r.idx));
      launch_wait(d);
      if (!r.bad && !vf) exp_lvl[r.blk == 7'h10] = r.w1[2:0];
      chk("access_error_flag", 32'(r.bad), 32'(d[5]));
      chk("pviol", 32'h0, 32'(d[4]));
      if (!r.bad) begin
         chk("verr", 32'(vf && r.inj != 2'h0), 32'(d[1]));
         chk("vunc", 32'(vf && r.inj == 2'h2), 32'(d[0]));
      end
      chk("levels", 32'({exp_lvl[1], exp_lvl[0]}), 32'(margin_levels));
      chk("reads", (vf && !r.bad) ? 32'(r.w2) : 32'h0, 32'(ack_total - ack_base));
      chk("irq", 32'h1, 32'(cmd_irq));
      if (r.bad) wr(fmv_pkg::FMV_STAT_OFS, 32'h00000020);
      $display("Test done: command %h block %h word %h", r.cmd, r.blk, r.w1);
   endtask

   // ====================================================================
   // Main sequence
   initial begin
      logic [31:0] d;
      logic e;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(fmv_pkg::FMV_STAT_OFS, d);
      chk("stat reset", 32'h00000080, d);
      rd(fmv_pkg::FMV_CFG_OFS, d);
      chk("cfg reset", 32'h00000000, d);
      chk("levels reset", 32'h0, 32'(margin_levels));
      chk("irq reset", 32'h0, 32'(cmd_irq));
      wr(fmv_pkg::FMV_CFG_OFS, 32'h00000080);
      for (int k = 0; k < NR; k++) run_row(ROWS[k]);
      // A pending access error blocks the next launch
      special_mode <= 1'b0;
      put(3'h0, {fmv_pkg::FMV_CMD_USER_MARGIN, 1'b0, 7'h7f});
      put(3'h1, 16'h0003);
      launch_wait(d);
      put(3'h1, 16'h0002);
      launch_wait(d);
      chk("blocked access_error_flag", 32'h1, 32'(d[5]));
      chk("blocked levels", 32'({exp_lvl[1], exp_lvl[0]}), 32'(margin_levels));
      wr(fmv_pkg::FMV_STAT_OFS, 32'h00000020);
      $display("Test done: launch while error pending");
      wr(fmv_pkg::FMV_CFG_OFS, 32'h00000000);
      chk("irq masked", 32'h0, 32'(cmd_irq));
      apb(1'b0, 8'h10, 32'h00000000, d, e);
      chk("unmapped err", 32'h1, 32'(e));
      chk("unmapped data", 32'h0, d);
      $display("Test done: mask and unmapped");
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk("levels rereset", 32'h0, 32'(margin_levels));
      $display("Test done: second reset");
      print_verdict();
   end
endmodule
